//--- common/bldet_pkg.sv
// Package of constants and carriers for the boot loader bit-rate detector
package bldet_pkg;
  // Register indices on the plain register port
  localparam logic [3:0] REG_WINDOW_CTRL = 4'h0;
  localparam logic [3:0] REG_EMU_AREA = 4'h1;
  localparam logic [3:0] REG_BOOT_STATUS = 4'h2;
  localparam logic [3:0] REG_DIVISOR = 4'h3;
  localparam logic [3:0] REG_LOW_COUNT = 4'h4;
  localparam logic [3:0] REG_SERIAL_CTRL = 4'h5;
  localparam logic [3:0] REG_FLASH_BASE = 4'h8;
  // Flash control window and program RAM range on the system bus
  localparam logic [23:0] FLASH_WIN_LO = 24'hff_ffc8;
  localparam logic [23:0] FLASH_WIN_HI = 24'hff_ffcb;
  localparam logic [23:0] PROG_RAM_LO = 24'hff_e400;
  localparam logic [23:0] PROG_RAM_HI = 24'hff_fbff;
  // Field positions
  localparam int WIN_SEL_BIT = 3;
  localparam int EMU_EN_BIT = 3;
  // Reset values and write masks
  localparam logic [7:0] EMU_AREA_RST = 8'h00;
  localparam logic [7:0] WINDOW_CTRL_RST = 8'h00;
  localparam logic [7:0] EMU_AREA_WMASK = 8'h0f;
  localparam logic [7:0] WINDOW_CTRL_WMASK = 8'h08;
  // Frame bytes
  localparam logic [7:0] SYNC_BYTE = 8'h00;
  localparam logic [7:0] DONE_BYTE = 8'h00;
  localparam logic [7:0] CONFIRM_BYTE = 8'h55;
  localparam int FRAME_DATA_BITS = 8;
  // Low period of a zero byte spans start plus eight data bits
  localparam int LOW_BITS = 9;
  localparam int COUNT_W = 20;
  localparam int CLK_MHZ = 200;
  // Boot sequence states, Gray along the usual path
  typedef enum logic [2:0] {
    BLDET_IDLE = 3'b000,
    BLDET_MEASURE = 3'b001,
    BLDET_SEND = 3'b011,
    BLDET_CONFIRM = 3'b010,
    BLDET_HANDOFF = 3'b110
  } bldet_state_t;
  // Serial unit control carrier
  typedef struct packed {
    logic receive_enable_bit;
    logic transmit_enable_bit;
    logic tx_pin_direction;
    logic tx_pin_level;
  } bldet_serial_ctrl_t;
  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } bldet_req_t;
endpackage : bldet_pkg

//--- logic/bldet_top.sv
// Boot loader bit-rate detector, serial hand-off and flash register window
//
// Overview of operation
// - Window select gates flash registers C8..CB
// - Low three select bits read zero
// - Emulation area clears on reset, standby
// - Emulation area upper nibble reads zero
// - Handoff clears enables, keeps divisor
// - Handoff leaves transmit pin driving high
// - Watchdog reset also ends boot mode
// - Measure low period of zero bytes
// - Frame is 8N1 both directions
// - Send one zero byte when adjusted
// - Divisor range covers 8..25 MHz clocks
`timescale 1ns/1ps
module bldet_top #(
  parameter int COUNT_W = bldet_pkg::COUNT_W
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic hw_standby,
  input wire logic watchdog_reset,
  input wire logic boot_mode,
  input wire logic rx_pin,
  output logic serial1_tx_pin,
  output logic serial1_tx_oe,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic boot_active,
  output logic handoff_done,
  output logic [23:0] handoff_addr,
  input wire logic [23:0] sys_addr,
  output logic flash_reg_hit,
  output logic emulation_enable,
  output logic [2:0] emu_area_sel,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready
);
  logic clear_all;
  logic rx_s1_q, rx_s2_q, rx_s3_q;
  bldet_pkg::bldet_state_t state_q;
  logic [COUNT_W-1:0] low_cnt_q;
  logic [COUNT_W-1:0] bit_rate_divisor_q;
  logic [COUNT_W-1:0] bit_cnt_q;
  logic [3:0] bit_idx_q;
  logic [9:0] tx_shift_q;
  logic tx_busy_q;
  logic [7:0] window_ctrl_q;
  logic [7:0] ram_emulation_area_q;
  bldet_pkg::bldet_serial_ctrl_t ser_q;
  logic [7:0] flash_regs_q [4];
  logic [7:0] rdata_q;
  logic rx_busy_q;
  logic [COUNT_W-1:0] rx_cnt_q;
  logic [3:0] rx_idx_q;
  logic [7:0] rx_shift_q;
  logic rx_byte_stb;
  logic [7:0] rx_byte;
  logic [7:0] buf_q [2];
  logic [1:0] buf_cnt_q;
  logic buf_wptr_q, buf_rptr_q;
  logic half_bit;

  // Pin reset, watchdog overflow and hardware standby all end boot mode
  assign clear_all = reset | watchdog_reset | hw_standby;

  // Two-stage synchroniser, third stage for edge detection
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_s3_q <= 1'b1;
    end else begin
      rx_s1_q <= rx_pin;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
    end
  end

  // Boot sequence: measure, reply, await confirmation, hand off
  always_ff @(posedge clk) begin
    if (clear_all) begin
      state_q <= bldet_pkg::BLDET_IDLE;
    end else begin
      case (state_q)
        bldet_pkg::BLDET_IDLE: begin
          if (boot_mode && rx_s3_q && !rx_s2_q) begin
            state_q <= bldet_pkg::BLDET_MEASURE;
          end
        end
        bldet_pkg::BLDET_MEASURE: begin
          if (rx_s2_q) begin
            state_q <= bldet_pkg::BLDET_SEND;
          end
        end
        bldet_pkg::BLDET_SEND: begin
          if (tx_busy_q && bit_idx_q == 4'd9 && bit_cnt_q == '0) begin
            state_q <= bldet_pkg::BLDET_CONFIRM;
          end
        end
        bldet_pkg::BLDET_CONFIRM: begin
          if (rx_byte_stb && rx_byte == bldet_pkg::CONFIRM_BYTE) begin
            state_q <= bldet_pkg::BLDET_HANDOFF;
          end
        end
        default: state_q <= state_q;
      endcase
    end
  end

  // Low-period counter; divisor is count over nine bit times
  always_ff @(posedge clk) begin
    if (clear_all) begin
      low_cnt_q <= '0;
    end else if (state_q == bldet_pkg::BLDET_IDLE) begin
      low_cnt_q <= '0;
    end else if (state_q == bldet_pkg::BLDET_MEASURE && !rx_s2_q && low_cnt_q != '1) begin
      low_cnt_q <= low_cnt_q + 1'b1;
    end
  end

  // Divisor loaded on the cycle the low period ends, ahead of the reply
  always_ff @(posedge clk) begin
    if (reset || hw_standby) begin
      bit_rate_divisor_q <= '0;
    end else if (state_q == bldet_pkg::BLDET_MEASURE && rx_s2_q) begin
      bit_rate_divisor_q <= COUNT_W'(low_cnt_q / bldet_pkg::LOW_BITS);
    end
  end

  // Transmitter: 8N1 frame, LSB first; sends the single done byte
  always_ff @(posedge clk) begin
    if (clear_all) begin
      tx_busy_q <= 1'b0;
      tx_shift_q <= '1;
      bit_idx_q <= '0;
      bit_cnt_q <= '0;
    end else if (state_q == bldet_pkg::BLDET_SEND && !tx_busy_q) begin
      tx_busy_q <= 1'b1;
      tx_shift_q <= {1'b1, bldet_pkg::DONE_BYTE, 1'b0};
      bit_idx_q <= '0;
      bit_cnt_q <= bit_rate_divisor_q;
    end else if (tx_busy_q) begin
      if (bit_cnt_q != '0) begin
        bit_cnt_q <= bit_cnt_q - 1'b1;
      end else if (bit_idx_q == 4'd9) begin
        tx_busy_q <= 1'b0;
        tx_shift_q <= '1;
      end else begin
        bit_idx_q <= bit_idx_q + 1'b1;
        tx_shift_q <= {1'b1, tx_shift_q[9:1]};
        bit_cnt_q <= bit_rate_divisor_q;
      end
    end
  end

  // Receiver samples mid-bit using the adjusted divisor
  assign half_bit = (rx_cnt_q == {1'b0, bit_rate_divisor_q[COUNT_W-1:1]});
  always_ff @(posedge clk) begin
    if (clear_all) begin
      rx_busy_q <= 1'b0;
      rx_cnt_q <= '0;
      rx_idx_q <= '0;
      rx_shift_q <= '0;
    end else if (!rx_busy_q) begin
      if (state_q == bldet_pkg::BLDET_CONFIRM && rx_s3_q && !rx_s2_q) begin
        rx_busy_q <= 1'b1;
        rx_cnt_q <= '0;
        rx_idx_q <= '0;
      end
    end else if (rx_cnt_q == bit_rate_divisor_q) begin
      rx_cnt_q <= '0;
    end else begin
      rx_cnt_q <= rx_cnt_q + 1'b1;
      if (half_bit) begin
        rx_idx_q <= rx_idx_q + 1'b1;
        if (rx_idx_q >= 4'd1 && rx_idx_q <= 4'd8) begin
          rx_shift_q <= {rx_s2_q, rx_shift_q[7:1]};
        end
        if (rx_idx_q == 4'd9) begin
          rx_busy_q <= 1'b0;
        end
      end
    end
  end
  // Good stop bit completes a byte
  assign rx_byte_stb = rx_busy_q && half_bit && rx_idx_q == 4'd9 && rx_s2_q;
  assign rx_byte = rx_shift_q;

  // Two-entry buffer toward the boot program; a full buffer drops no held word
  always_ff @(posedge clk) begin
    if (clear_all) begin
      buf_cnt_q <= '0;
      buf_wptr_q <= 1'b0;
      buf_rptr_q <= 1'b0;
    end else begin
      if (rx_byte_stb && buf_cnt_q != 2'd2) begin
        buf_q[buf_wptr_q] <= rx_byte;
        buf_wptr_q <= ~buf_wptr_q;
      end
      if (rx_valid && rx_ready) begin
        buf_rptr_q <= ~buf_rptr_q;
      end
      buf_cnt_q <= buf_cnt_q + 2'(rx_byte_stb && buf_cnt_q != 2'd2) - 2'(rx_valid && rx_ready);
    end
  end
  assign rx_valid = (buf_cnt_q != 2'd0);
  assign rx_data = buf_q[buf_rptr_q];

  // Serial control: enabled during adjustment, stopped at hand-off
  always_ff @(posedge clk) begin
    if (clear_all) begin
      ser_q <= '{receive_enable_bit: 1'b0, transmit_enable_bit: 1'b0, tx_pin_direction: 1'b0, tx_pin_level: 1'b1};
    end else if (state_q == bldet_pkg::BLDET_HANDOFF) begin
      ser_q.receive_enable_bit <= 1'b0;
      ser_q.transmit_enable_bit <= 1'b0;
      ser_q.tx_pin_direction <= 1'b1;
      ser_q.tx_pin_level <= 1'b1;
    end else if (state_q != bldet_pkg::BLDET_IDLE) begin
      ser_q.receive_enable_bit <= 1'b1;
      ser_q.transmit_enable_bit <= 1'b1;
    end
  end

  // Pin drive: serial data while transmitting, port level after hand-off
  assign serial1_tx_pin = ser_q.transmit_enable_bit ? tx_shift_q[0] : ser_q.tx_pin_level;
  assign serial1_tx_oe = ser_q.transmit_enable_bit | ser_q.tx_pin_direction;
  assign boot_active = (state_q != bldet_pkg::BLDET_IDLE);
  assign handoff_done = (state_q == bldet_pkg::BLDET_HANDOFF);
  assign handoff_addr = bldet_pkg::PROG_RAM_LO;

  // Window select register; only the select bit is writable
  always_ff @(posedge clk) begin
    if (reset || hw_standby) begin
      window_ctrl_q <= bldet_pkg::WINDOW_CTRL_RST;
    end else if (reg_wr && reg_addr == bldet_pkg::REG_WINDOW_CTRL) begin
      window_ctrl_q <= reg_wdata & bldet_pkg::WINDOW_CTRL_WMASK;
    end
  end

  // Emulation area: kept through software standby, cleared by hardware standby
  always_ff @(posedge clk) begin
    if (reset || hw_standby) begin
      ram_emulation_area_q <= bldet_pkg::EMU_AREA_RST;
    end else if (reg_wr && reg_addr == bldet_pkg::REG_EMU_AREA) begin
      ram_emulation_area_q <= reg_wdata & bldet_pkg::EMU_AREA_WMASK;
    end
  end
  // Next access after a write may misbehave; software must not rely on it
  assign emulation_enable = ram_emulation_area_q[bldet_pkg::EMU_EN_BIT];
  assign emu_area_sel = ram_emulation_area_q[2:0];

  // Flash control registers keep contents while unselected
  always_ff @(posedge clk) begin
    if (reset || hw_standby) begin
      for (int i = 0; i < 4; i++) begin
        flash_regs_q[i] <= 8'h00;
      end
    end else if (reg_wr && window_ctrl_q[bldet_pkg::WIN_SEL_BIT] && reg_addr[3:2] == bldet_pkg::REG_FLASH_BASE[3:2]) begin
      flash_regs_q[reg_addr[1:0]] <= reg_wdata;
    end
  end
  assign flash_reg_hit = window_ctrl_q[bldet_pkg::WIN_SEL_BIT] &&
    sys_addr >= bldet_pkg::FLASH_WIN_LO && sys_addr <= bldet_pkg::FLASH_WIN_HI;

  // Read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= 8'h00;
    end else if (!reg_rd) begin
      rdata_q <= 8'h00;
    end else if (reg_addr == bldet_pkg::REG_WINDOW_CTRL) begin
      rdata_q <= window_ctrl_q;
    end else if (reg_addr == bldet_pkg::REG_EMU_AREA) begin
      rdata_q <= ram_emulation_area_q;
    end else if (reg_addr == bldet_pkg::REG_BOOT_STATUS) begin
      rdata_q <= {5'b0, state_q};
    end else if (reg_addr == bldet_pkg::REG_DIVISOR) begin
      rdata_q <= bit_rate_divisor_q[7:0];
    end else if (reg_addr == bldet_pkg::REG_LOW_COUNT) begin
      rdata_q <= low_cnt_q[7:0];
    end else if (reg_addr == bldet_pkg::REG_SERIAL_CTRL) begin
      rdata_q <= {4'b0, ser_q};
    end else if (reg_addr[3:2] == bldet_pkg::REG_FLASH_BASE[3:2] && window_ctrl_q[bldet_pkg::WIN_SEL_BIT]) begin
      rdata_q <= flash_regs_q[reg_addr[1:0]];
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign reg_rdata = rdata_q;
endmodule : bldet_top

//--- verification/bldet_host_model.sv
// Host partner: sends framed bytes and decodes the device replies
`timescale 1ns/1ps
module bldet_host_model #(
  parameter int BIT_CYC = 40
) (
  input wire logic clk,
  input wire logic send_req,
  input wire logic [7:0] send_byte,
  input wire logic dev_tx,
  output logic host_tx,
  output logic [7:0] reply,
  output logic [7:0] reply_cnt,
  output logic busy
);
  // One bit cell; bit time scaled down from the host rate to keep runs short
  task automatic put_bit(input logic b);
    host_tx <= b;
    repeat (BIT_CYC) @(posedge clk);
  endtask : put_bit
  // Transmitter: start bit, eight data bits LSB first, one stop bit, idle high
  initial begin
    host_tx = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (send_req === 1'b1) begin
        busy = 1'b1;
        put_bit(1'b0);
        for (int i = 0; i < 8; i++) put_bit(send_byte[i]);
        put_bit(1'b1);
        busy = 1'b0;
      end
    end
  end
  // Receiver samples mid-cell, so a divisor a cycle off still decodes
  initial begin
    reply = 8'h00;
    reply_cnt = 8'h00;
    forever begin
      @(negedge dev_tx);
      repeat (BIT_CYC + BIT_CYC / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        reply[i] = dev_tx;
        repeat (BIT_CYC) @(posedge clk);
      end
      reply_cnt = reply_cnt + 8'h01;
    end
  end
endmodule : bldet_host_model

//--- verification/bldet_properties.sv
// Port-level assertions for the boot loader bit-rate detector
`timescale 1ns/1ps
module bldet_properties #(
  parameter int COUNT_W = 20
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic hw_standby,
  input wire logic watchdog_reset,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic boot_active,
  input wire logic handoff_done,
  input wire logic [23:0] handoff_addr,
  input wire logic [23:0] sys_addr,
  input wire logic flash_reg_hit,
  input wire logic emulation_enable,
  input wire logic [2:0] emu_area_sel,
  input wire logic serial1_tx_pin,
  input wire logic serial1_tx_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic win_q;
  // Shadow of the window select bit, cleared like the real one
  always_ff @(posedge clk) begin
    if (reset || hw_standby) win_q <= 1'b0;
    else if (reg_wr && reg_addr == bldet_pkg::REG_WINDOW_CTRL) win_q <= reg_wdata[3];
  end
  sequence s_win_rd; reg_rd && reg_addr == bldet_pkg::REG_WINDOW_CTRL; endsequence
  sequence s_emu_rd; reg_rd && reg_addr == bldet_pkg::REG_EMU_AREA; endsequence
  sequence s_emu_wr; reg_wr && !hw_standby && reg_addr == bldet_pkg::REG_EMU_AREA; endsequence
  a_win_hit_gate: assert property (flash_reg_hit == (win_q && sys_addr >= bldet_pkg::FLASH_WIN_LO
    && sys_addr <= bldet_pkg::FLASH_WIN_HI)) else $error("flash window decode wrong");
  a_win_low_zero: assert property (s_win_rd |=> reg_rdata[2:0] == 3'h0)
    else $error("window low bits not zero");
  a_emu_clear: assert property (hw_standby |=> {emulation_enable, emu_area_sel} == 4'h0)
    else $error("emulation area not cleared");
  a_emu_upper: assert property (s_emu_rd |=> reg_rdata[7:4] == 4'h0)
    else $error("emulation upper bits not zero");
  a_emu_write: assert property (s_emu_wr |=> {emulation_enable, emu_area_sel} == $past(reg_wdata[3:0]))
    else $error("emulation field not written");
  a_handoff_addr: assert property (handoff_done |-> handoff_addr == bldet_pkg::PROG_RAM_LO)
    else $error("hand-off address wrong");
  a_handoff_pin: assert property (handoff_done |-> serial1_tx_oe && serial1_tx_pin)
    else $error("transmit pin not driven high");
  a_wdog_ends: assert property (watchdog_reset |=> !boot_active && !handoff_done)
    else $error("boot mode kept after watchdog");
endmodule : bldet_properties

bind bldet_top bldet_properties #(.COUNT_W(COUNT_W)) u_props (.clk(clk), .reset(reset),
  .hw_standby(hw_standby), .watchdog_reset(watchdog_reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .boot_active(boot_active),
  .handoff_done(handoff_done), .handoff_addr(handoff_addr), .sys_addr(sys_addr), .flash_reg_hit(flash_reg_hit),
  .emulation_enable(emulation_enable), .emu_area_sel(emu_area_sel), .serial1_tx_pin(serial1_tx_pin),
  .serial1_tx_oe(serial1_tx_oe));

//--- verification/boot_loader_baud_detect_tb.sv
// Self-checking bench for the boot loader bit-rate detector
`timescale 1ns/1ps
module boot_loader_baud_detect_tb;
  localparam int BIT_CYC = 40;
  logic clk, reset, hw_standby, watchdog_reset, boot_mode, rx_pin, tx_pin, tx_oe, send_req, host_busy;
  logic reg_wr, reg_rd, boot_active, handoff_done, flash_reg_hit, emulation_enable, rx_valid, rx_ready;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rx_data, rd_v, reply, reply_cnt, send_byte, x;
  logic [2:0] emu_area_sel;
  logic [23:0] handoff_addr, sys_addr;
  logic [31:0] seed = 32'h0000_0003;
  logic [7:0] exp_q[$];
  logic [7:0] flash_m[4];
  int fail_count = 0;
  int n_compared = 0;
  bldet_top u_dut (.clk(clk), .reset(reset), .hw_standby(hw_standby), .watchdog_reset(watchdog_reset),
    .boot_mode(boot_mode), .rx_pin(rx_pin), .serial1_tx_pin(tx_pin), .serial1_tx_oe(tx_oe),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .boot_active(boot_active), .handoff_done(handoff_done), .handoff_addr(handoff_addr), .sys_addr(sys_addr),
    .flash_reg_hit(flash_reg_hit), .emulation_enable(emulation_enable), .emu_area_sel(emu_area_sel),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready));
  bldet_host_model #(.BIT_CYC(BIT_CYC)) u_host (.clk(clk), .send_req(send_req), .send_byte(send_byte),
    .dev_tx(tx_pin), .host_tx(rx_pin), .reply(reply), .reply_cnt(reply_cnt), .busy(host_busy));
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Bus cycles start just after an edge and leave a free edge behind
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask : rd
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk(v, e);
  endtask : rdc
  task automatic hit(input logic [23:0] a, input logic e);
    sys_addr <= a;
    @(negedge clk);
    chk(flash_reg_hit, e);
    @(posedge clk);
  endtask : hit
  // Host sends one byte; wait on its busy flag, bounded
  task automatic send(input logic [7:0] b);
    send_byte <= b;
    send_req <= 1'b1;
    @(posedge clk);
    send_req <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 20 * BIT_CYC && host_busy; i++) @(posedge clk);
    repeat (8) @(posedge clk);
  endtask : send
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  // Free-running 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Hang guard, well above the few thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    conclude();
  end
  // Main sequence; the mode strap is held constant throughout
  initial begin
    reset = 1'b1; hw_standby = 1'b0; watchdog_reset = 1'b0; boot_mode = 1'b1; rx_ready = 1'b0;
    reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0; reg_wdata = 8'h00; sys_addr = 24'h00_0000;
    send_req = 1'b0; send_byte = 8'h00;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    wr(bldet_pkg::REG_WINDOW_CTRL, 8'hff);
    rdc(bldet_pkg::REG_WINDOW_CTRL, 8'h08);
    for (int i = 0; i < 6; i++) hit(24'hff_ffc7 + 24'(i), i >= 1 && i <= 4);
    for (int i = 0; i < 4; i++) begin
      flash_m[i] = rnd();
      wr(bldet_pkg::REG_FLASH_BASE + 4'(i), flash_m[i]);
    end
    wr(bldet_pkg::REG_WINDOW_CTRL, 8'h00);
    rdc(bldet_pkg::REG_FLASH_BASE, 8'h00);
    hit(24'hff_ffc8, 1'b0);
    wr(bldet_pkg::REG_WINDOW_CTRL, 8'h08);
    for (int i = 0; i < 4; i++) rdc(bldet_pkg::REG_FLASH_BASE + 4'(i), flash_m[i]);
    $display("test window done");
    x = rnd();
    // The access after this write stays off the emulated flash region
    wr(bldet_pkg::REG_EMU_AREA, x);
    rdc(bldet_pkg::REG_EMU_AREA, x & 8'h0f);
    chk({emulation_enable, emu_area_sel}, x[3:0]);
    hw_standby <= 1'b1;
    @(posedge clk);
    hw_standby <= 1'b0;
    rdc(bldet_pkg::REG_EMU_AREA, 8'h00);
    wr(bldet_pkg::REG_EMU_AREA, 8'hff);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rdc(bldet_pkg::REG_EMU_AREA, 8'h00);
    $display("test emulation done");
    // A garbled sync gives a reply at the wrong rate; the host resets and starts over
    x = reply_cnt;
    send(8'hf0);
    for (int i = 0; i < 30 * BIT_CYC && reply_cnt == x; i++) @(posedge clk);
    chk(reply_cnt, x + 8'h01);
    chk(reply === bldet_pkg::DONE_BYTE, 1'b0);
    reset <= 1'b1;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk({boot_active, handoff_done}, 2'b00);
    $display("test retry done");
    x = reply_cnt;
    send(bldet_pkg::SYNC_BYTE);
    for (int i = 0; i < 30 * BIT_CYC && reply_cnt == x; i++) @(posedge clk);
    chk(reply_cnt, x + 8'h01);
    chk(reply, bldet_pkg::DONE_BYTE);
    // Nine low bit times minus the edge spent leaving idle, then one bit time less one
    rd(bldet_pkg::REG_DIVISOR, rd_v);
    chk(rd_v, 24'(BIT_CYC - 1));
    rdc(bldet_pkg::REG_LOW_COUNT, 8'(9 * BIT_CYC - 1));
    repeat (2 * BIT_CYC) @(posedge clk);
    exp_q.push_back(8'h5a);
    send(8'h5a);
    chk({boot_active, handoff_done}, 2'b10);
    exp_q.push_back(bldet_pkg::CONFIRM_BYTE);
    send(bldet_pkg::CONFIRM_BYTE);
    chk({handoff_done, tx_oe, tx_pin}, 3'b111);
    rdc(bldet_pkg::REG_SERIAL_CTRL, 8'h03);
    rdc(bldet_pkg::REG_DIVISOR, 8'(BIT_CYC - 1));
    chk(handoff_addr, 24'hff_e400);
    rx_ready <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      if (rx_valid === 1'b1 && rx_ready === 1'b1) chk(rx_data, exp_q.pop_front());
    end
    chk(exp_q.size(), 0);
    $display("test boot done");
    watchdog_reset <= 1'b1;
    @(posedge clk);
    watchdog_reset <= 1'b0;
    @(posedge clk);
    chk({boot_active, handoff_done}, 2'b00);
    rdc(bldet_pkg::REG_DIVISOR, 8'(BIT_CYC - 1));
    $display("test watchdog done");
    conclude();
  end
endmodule : boot_loader_baud_detect_tb
